//--- hdl/acd_filter.sv
// digital glitch filter for one comparator output
`timescale 1ns/1ps
module acd_filter import acd_pkg::*; #(
  parameter int unsigned N = FILTER_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // sample and control
  input wire logic din,
  input wire logic on,
  // filtered level
  output logic dout
);

  initial begin
    if (N < 2 || N > 256) begin
      $error("acd_filter: N out of range");
    end
  end

  // the changing sample counts as the first of the N equal ones
  localparam logic [7:0] CNT_LAST = 8'(N - 2);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic last_q;
  logic last_d;
  logic out_q;
  logic out_d;

  // with the filter on, output only moves once the input held one level for N clocks; off, it follows din
  always_comb begin
    last_d = din;
    cnt_d = cnt_q;
    out_d = out_q;
    if (!on) begin
      cnt_d = 8'h00;
      out_d = din;
    end else if (din != last_q) begin
      cnt_d = 8'h00;
    end else if (cnt_q == CNT_LAST) begin
      out_d = last_q;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      last_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      last_q <= last_d;
      out_q <= out_d;
    end
  end

  // bypass keeps the path combinational so an off filter adds no delay
  assign dout = on ? out_q : din;

  a_filter_wait: assert property (@(posedge clk) disable iff (!rst_b)
    (on && $past(on) && (out_q != $past(out_q))) |-> ($past(cnt_q) == CNT_LAST))
    else $error("filtered output moved before the input was stable");

endmodule

//--- hdl/acd_top.sv
// control logic for four comparators and two threshold dacs
`timescale 1ns/1ps
module acd_top import acd_pkg::*; #(
  parameter int unsigned NCMP = 4,
  parameter int unsigned FILT_N = FILTER_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // cpu register port
  input wire acd_bus_req_t bus_req,
  output logic [7:0] rdata_q,
  // raw comparator outputs from the analog cores
  input wire logic [3:0] cmp_raw,
  // analog control bundle and interrupt
  output acd_analog_t ana_q,
  output logic irq_q
);

  initial begin
    if (NCMP != 4) begin
      $error("acd_top: register map serves exactly four comparators");
    end
    if (FILT_N < 2) begin
      $error("acd_top: filter length too short");
    end
  end

  // nibble of comparator i from the two config bytes
  function automatic logic [3:0] cfg_nib(input logic [15:0] cfg, input int i);
    cfg_nib = cfg[15 - 4 * i -: 4];
  endfunction

  // threshold source of comparator i
  function automatic acd_thr_src_t thr_src(input int i, input logic pick);
    if (!pick) begin
      thr_src = THR_LEVEL_ZERO;
    end else if (i == 0) begin
      thr_src = THR_LEVEL_ONE;
    end else begin
      thr_src = THR_EXTERNAL;
    end
  endfunction

  function automatic logic hit(input acd_bus_req_t r, input logic [15:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // ---------------- input synchroniser ----------------
  logic [3:0] raw_s1_q;
  logic [3:0] raw_s2_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_s1_q <= RST_NIBBLE;
      raw_s2_q <= RST_NIBBLE;
    end else begin
      raw_s1_q <= cmp_raw;
      raw_s2_q <= raw_s1_q;
    end
  end

  // ---------------- registers ----------------
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [7:0] lvl0_q;
  logic [7:0] lvl0_d;
  logic [7:0] lvl1_q;
  logic [7:0] lvl1_d;
  logic [7:0] dac_q;
  logic [7:0] dac_d;
  logic [3:0] filt_on_q;
  logic [3:0] filt_on_d;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic [3:0] log_q;
  logic [3:0] log_d;
  logic [3:0] flag_q;
  logic [3:0] flag_d;
  logic [3:0] live_q;
  logic [3:0] live_d;
  logic [7:0] rdata_d;
  logic irq_d;
  acd_analog_t ana_d;

  logic [3:0] en;
  logic [3:0] inv;
  logic [3:0] irq_on;
  logic [3:0] pick;
  logic [3:0] pol;
  logic [3:0] filt;
  logic [3:0] toggle;
  logic [3:0] flag_clr;
  logic [3:0] log_clr;

  always_comb begin
    logic [3:0] nib;
    nib = RST_NIBBLE;
    for (int i = 0; i < 4; i++) begin
      nib = cfg_nib(cfg_q, i);
      en[i] = nib[NIB_EN];
      inv[i] = nib[NIB_INV];
      irq_on[i] = nib[NIB_IRQ];
      pick[i] = nib[NIB_PICK];
    end
  end

  // polarity ahead of the filter so the filter sees the reported sense
  assign pol = raw_s2_q ^ inv;

  for (genvar g = 0; g < 4; g++) begin : g_filt
    acd_filter #(
      .N(FILT_N)
    ) u_filt (
      .clk(clk),
      .rst_b(rst_b),
      .din(pol[g]),
      .on(filt_on_q[g]),
      .dout(filt[g])
    );
  end

  always_comb begin
    live_d = filt & en;
    // either direction counts; a disabled comparator never flags
    toggle = en & (live_d ^ live_q);
  end

  // register writes
  always_comb begin
    cfg_d = cfg_q;
    lvl0_d = lvl0_q;
    lvl1_d = lvl1_q;
    dac_d = dac_q;
    filt_on_d = filt_on_q;
    mask_d = mask_q;
    flag_clr = RST_NIBBLE;
    log_clr = RST_NIBBLE;
    if (hit(bus_req, OFS_CFG_AB)) begin
      cfg_d[15:8] = bus_req.wdata;
    end
    if (hit(bus_req, OFS_CFG_CD)) begin
      cfg_d[7:0] = bus_req.wdata;
    end
    if (hit(bus_req, OFS_LEVEL_ZERO)) begin
      lvl0_d = bus_req.wdata;
    end
    if (hit(bus_req, OFS_LEVEL_ONE)) begin
      lvl1_d = bus_req.wdata;
    end
    if (hit(bus_req, OFS_DAC_CFG)) begin
      dac_d = bus_req.wdata & DAC_CFG_WMASK;
    end
    if (hit(bus_req, OFS_STATUS)) begin
      filt_on_d = bus_req.wdata[3:0];
      flag_clr = ~bus_req.wdata[ST_FLAG_LSB +: 4];
    end
    if (hit(bus_req, OFS_IRQ_MASK)) begin
      mask_d = bus_req.wdata[3:0];
    end
    if (hit(bus_req, OFS_EVENT_LOG)) begin
      log_clr = bus_req.wdata[3:0];
    end
  end

  // sticky bits: a set in the clearing cycle wins
  always_comb begin
    flag_d = (flag_q & ~flag_clr) | toggle;
    log_d = (log_q & ~log_clr) | toggle;
    irq_d = |(flag_q & irq_on & mask_q);
  end

  // read mux; unmapped addresses and idle cycles read zero
  always_comb begin
    rdata_d = RD_IDLE;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CFG_AB: rdata_d = cfg_q[15:8];
        OFS_CFG_CD: rdata_d = cfg_q[7:0];
        OFS_LEVEL_ZERO: rdata_d = lvl0_q;
        OFS_LEVEL_ONE: rdata_d = lvl1_q;
        OFS_DAC_CFG: rdata_d = dac_q;
        OFS_STATUS: rdata_d = {flag_q, live_q};
        OFS_IRQ_MASK: rdata_d = {RST_NIBBLE, mask_q};
        OFS_EVENT_LOG: rdata_d = {RST_NIBBLE, log_q};
        default: rdata_d = RD_IDLE;
      endcase
    end
  end

  // analog control bundle
  always_comb begin
    ana_d.cmp_on = en;
    ana_d.hyst_on = dac_q[3:0];
    for (int i = 0; i < 4; i++) begin
      ana_d.thr_src[i] = thr_src(i, pick[i]);
    end
    ana_d.level_zero = lvl0_q;
    ana_d.level_one = lvl1_q;
    ana_d.buf_on = dac_q[DAC_BIT_BUF];
    ana_d.loop_test = dac_q[DAC_BIT_LOOP];
    ana_d.vddc_pin = dac_q[DAC_BIT_VDDC];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= {RST_CFG, RST_CFG};
      lvl0_q <= RST_LEVEL;
      lvl1_q <= RST_LEVEL;
      dac_q <= RST_DAC_CFG;
      filt_on_q <= RST_NIBBLE;
      mask_q <= RST_IRQ_MASK;
      log_q <= RST_NIBBLE;
      flag_q <= RST_NIBBLE;
      live_q <= RST_NIBBLE;
      rdata_q <= RD_IDLE;
      irq_q <= 1'b0;
      ana_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      lvl0_q <= lvl0_d;
      lvl1_q <= lvl1_d;
      dac_q <= dac_d;
      filt_on_q <= filt_on_d;
      mask_q <= mask_d;
      log_q <= log_d;
      flag_q <= flag_d;
      live_q <= live_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      ana_q <= ana_d;
    end
  end

  // ---------------- checks ----------------
  a_live_gated_off: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> ((live_q & ~$past(en)) == 4'h0))
    else $error("live bit set for a disabled comparator");

  a_flag_on_toggle: assert property (@(posedge clk) disable iff (!rst_b)
    (toggle != 4'h0) |=> ((flag_q & $past(toggle)) == $past(toggle)))
    else $error("toggle did not set its flag");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    (!hit(bus_req, OFS_STATUS)) |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
    else $error("flag dropped without a clearing write");

  a_flag_clear_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (hit(bus_req, OFS_STATUS) && !bus_req.wdata[ST_FLAG_LSB] && !toggle[0])
      |=> !flag_q[0])
    else $error("writing zero did not clear the flag");

  a_irq_needs_enable: assert property (@(posedge clk) disable iff (!rst_b)
    irq_q |-> $past((flag_q & irq_on) != 4'h0))
    else $error("interrupt without an enabled flag");

  a_irq_follows_flag: assert property (@(posedge clk) disable iff (!rst_b)
    ((flag_q & irq_on & mask_q) != 4'h0) ##1 ((flag_q & irq_on & mask_q) != 4'h0)
      |-> irq_q)
    else $error("enabled flag did not raise the interrupt");

  a_pick_first: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> (ana_q.thr_src[0] == ($past(pick[0]) ? THR_LEVEL_ONE : THR_LEVEL_ZERO)))
    else $error("first comparator given the external threshold");

  a_pick_others: assert property (@(posedge clk) disable iff (!rst_b)
    (hit(bus_req, OFS_CFG_CD) && bus_req.wdata[4 + NIB_PICK]) |-> ##2
      (ana_q.thr_src[2] == THR_EXTERNAL) || $past(hit(bus_req, OFS_CFG_CD)))
    else $error("third comparator pick did not select the external input");

  a_level_one_dac: assert property (@(posedge clk) disable iff (!rst_b)
    hit(bus_req, OFS_LEVEL_ONE) ##1 !hit(bus_req, OFS_LEVEL_ONE)
      |=> (ana_q.level_one == $past(bus_req.wdata, 2)))
    else $error("dac output code does not follow level one");

  a_read_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    !bus_req.rd |=> (rdata_q == RD_IDLE))
    else $error("read data present without a read");

  c_flag_set: cover property (@(posedge clk) disable iff (!rst_b) toggle[0] ##1 flag_q[0]);
  c_irq_raise: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq_q));
  c_clear_race: cover property (@(posedge clk) disable iff (!rst_b)
    hit(bus_req, OFS_STATUS) && (toggle != 4'h0));
  c_filtered_edge: cover property (@(posedge clk) disable iff (!rst_b)
    filt_on_q[0] && toggle[0]);

endmodule

//--- include/acd_pkg.sv
// shared constants and types for the comparator and threshold dac control
package acd_pkg;

  // register offsets on the plain cpu port
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [15:0] OFS_CFG_AB = 16'hA038;
  localparam logic [15:0] OFS_CFG_CD = 16'hA039;
  localparam logic [15:0] OFS_LEVEL_ZERO = 16'hA03A;
  localparam logic [15:0] OFS_LEVEL_ONE = 16'hA03B;
  localparam logic [15:0] OFS_DAC_CFG = 16'hA03C;
  localparam logic [15:0] OFS_STATUS = 16'hA03D;
  localparam logic [15:0] OFS_IRQ_MASK = 16'hA03E;
  localparam logic [15:0] OFS_EVENT_LOG = 16'hA03F;

  // reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] RST_DAC_CFG = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [3:0] RST_IRQ_MASK = 4'hF;
  localparam logic [7:0] RD_IDLE = 8'h00;

  // per-comparator nibble of a config byte, first comparator in the high nibble
  localparam int unsigned NIB_EN = 3;
  localparam int unsigned NIB_PICK = 2;
  localparam int unsigned NIB_IRQ = 1;
  localparam int unsigned NIB_INV = 0;

  // dac and hysteresis byte
  localparam int unsigned DAC_BIT_BUF = 7;
  localparam int unsigned DAC_BIT_VDDC = 6;
  localparam int unsigned DAC_BIT_LOOP = 5;
  localparam logic [7:0] DAC_CFG_WMASK = 8'hEF;

  // status byte: flags high, live outputs / filter enables low
  localparam int unsigned ST_FLAG_LSB = 4;

  // timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned FILTER_CYCLES = 16;
  localparam int unsigned SETTLE_US = 20;
  localparam int unsigned SETTLE_CYCLES = SETTLE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    THR_LEVEL_ZERO,
    THR_LEVEL_ONE,
    THR_EXTERNAL
  } acd_thr_src_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acd_bus_req_t;

  typedef struct packed {
    logic [3:0] cmp_on;
    logic [3:0] hyst_on;
    acd_thr_src_t [3:0] thr_src;
    logic [7:0] level_zero;
    logic [7:0] level_one;
    logic buf_on;
    logic loop_test;
    logic vddc_pin;
  } acd_analog_t;

endpackage

//--- tb/acd_cmp_model.sv
// behavioural model of the four comparator cores and their threshold muxes
`timescale 1ns/1ps
module acd_cmp_model import acd_pkg::*; (
  // analog controls from the block
  input wire acd_analog_t ana,
  // input voltages as codes and the external threshold
  input wire logic [3:0][7:0] vin,
  input wire logic [7:0] ext_th,
  // raw comparator outputs
  output logic [3:0] cmp_raw
);
  logic [7:0] th;

  always_comb begin
    cmp_raw = 4'h0;
    for (int i = 0; i < 4; i++) begin
      case (ana.thr_src[i])
        THR_LEVEL_ONE: th = ana.level_one;
        THR_EXTERNAL: th = ext_th;
        default: th = ana.level_zero;
      endcase
      // an unbiased core has no defined level, so it is not forced low here
      cmp_raw[i] = vin[i] > th;
    end
  end
endmodule

//--- tb/tb.sv
// self-checking bench for the comparator and threshold dac control
`timescale 1ns/1ps
module tb import acd_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  acd_bus_req_t req = '0;
  logic [7:0] rdata_q;
  logic [3:0] cmp_raw;
  acd_analog_t ana_q;
  logic irq_q;
  logic [3:0][7:0] vin = '0;
  logic [7:0] ext_th = 8'h80;
  logic rd_p = 1'b0;
  logic [7:0] exp_q[$];
  int errors = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  acd_top #(.NCMP(4), .FILT_N(FILTER_CYCLES)) u_acd_top (
    .clk(clk),
    .rst_b(rst_b),
    .bus_req(req),
    .rdata_q(rdata_q),
    .cmp_raw(cmp_raw),
    .ana_q(ana_q),
    .irq_q(irq_q)
  );

  acd_cmp_model u_acd_cmp_model (
    .ana(ana_q),
    .vin(vin),
    .ext_th(ext_th),
    .cmp_raw(cmp_raw)
  );

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // every field is set once per cycle, so back-to-back strobes never clash
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(a, d, 1'b1, 1'b0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 8'h00, 1'b0, 1'b1);
  endtask

  task automatic idle(input int n);
    bus(16'h0000, 8'h00, 1'b0, 1'b0);
    repeat (n - 1) @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_p <= req.rd;
  always @(negedge clk) begin
    if (rd_p) begin
      chk("rdata_q", rdata_q, exp_q.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    logic [7:0] d;
    void'($urandom(45276));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // reset values, the mask register and one unmapped place
    for (int i = 0; i < 9; i++) begin
      rd(16'hA038 + 16'(i), (i == 6) ? 8'h0F : 8'h00);
    end
    idle(1);
    chk("irq_q", 8'(irq_q), 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(16'hA03A + 16'(i), d);
      rd(16'hA03A + 16'(i), (i == 2) ? (d & DAC_CFG_WMASK) : d);
      idle(2);
      chk("ana_q", (i == 0) ? ana_q.level_zero : (i == 1) ? ana_q.level_one :
          {ana_q.buf_on, ana_q.vddc_pin, ana_q.loop_test, 1'b0, ana_q.hyst_on},
          (i == 2) ? (d & DAC_CFG_WMASK) : d);
    end
    wr(OFS_CFG_AB, 8'h44);
    wr(OFS_CFG_CD, 8'h44);
    idle(2);
    chk("thr_src", 8'(ana_q.thr_src[0]), 8'(THR_LEVEL_ONE));
    for (int i = 1; i < 4; i++) begin
      chk("thr_src", 8'(ana_q.thr_src[i]), 8'(THR_EXTERNAL));
    end
    wr(OFS_LEVEL_ZERO, 8'h80);
    for (int i = 0; i < 4; i++) begin
      vin[i] <= 8'($urandom_range(127));
    end
    wr(OFS_CFG_AB, 8'hAA);
    wr(OFS_CFG_CD, 8'hAA);
    idle(2);
    chk("cmp_on", 8'(ana_q.cmp_on), 8'h0F);
    chk("thr_src", 8'(ana_q.thr_src[3]), 8'(THR_LEVEL_ZERO));
    idle(SETTLE_CYCLES);
    rd(OFS_STATUS, 8'h00);
    vin[0] <= 8'h81 + 8'($urandom_range(126));
    idle(8);
    chk("irq_q", 8'(irq_q), 8'h01);
    rd(OFS_STATUS, 8'h11);
    wr(OFS_STATUS, 8'hF0);
    rd(OFS_STATUS, 8'h11);
    wr(OFS_STATUS, 8'h00);
    idle(3);
    chk("irq_q", 8'(irq_q), 8'h00);
    rd(OFS_STATUS, 8'h01);
    vin[0] <= 8'($urandom_range(127));
    idle(8);
    rd(OFS_STATUS, 8'h10);
    wr(OFS_STATUS, 8'h00);
    wr(OFS_CFG_AB, 8'hBA);
    idle(8);
    rd(OFS_STATUS, 8'h11);
    wr(OFS_STATUS, 8'h00);
    wr(OFS_CFG_AB, 8'h9A);
    vin[0] <= 8'hFF;
    idle(8);
    chk("irq_q", 8'(irq_q), 8'h00);
    rd(OFS_STATUS, 8'h10);
    vin[1] <= 8'hFF;
    idle(8);
    rd(OFS_STATUS, 8'h32);
    wr(OFS_STATUS, 8'h00);
    wr(OFS_CFG_AB, 8'h92);
    idle(8);
    rd(OFS_STATUS, 8'h00);
    vin <= '0;
    wr(OFS_CFG_AB, 8'hAA);
    idle(SETTLE_CYCLES);
    wr(OFS_STATUS, 8'h01);
    vin[0] <= 8'hFF;
    // a pulse shorter than the filter span must vanish
    idle(FILTER_CYCLES - 4);
    vin[0] <= 8'h00;
    idle(30);
    rd(OFS_STATUS, 8'h00);
    vin[0] <= 8'hFF;
    idle(30);
    rd(OFS_STATUS, 8'h11);
    idle(3);
    chk("irq_q", 8'(irq_q), 8'h01);
    rd(OFS_EVENT_LOG, 8'h03);
    wr(OFS_IRQ_MASK, 8'h0E);
    wr(OFS_EVENT_LOG, 8'h01);
    idle(3);
    chk("irq_q", 8'(irq_q), 8'h00);
    rd(OFS_EVENT_LOG, 8'h02);
    idle(3);
    report_and_stop();
  end
endmodule
